// File: char_lcd_command_decoder_bench.sv
`timescale 1ns/1ps
module char_lcd_command_decoder_bench import clcd_pkg::*;;
  typedef struct packed {
    logic [9:0] c;
    logic [2:0] dcb;
    logic [6:0] ptr;
    logic [6:0] sh;
  } clcd_row_type;
  logic sys_clk = 1'b0;
  logic sys_rst, avs_read, avs_write, cap, en_q, two_line, busy_indicator;
  logic disp_on, cursor_vis, blink_on;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic avs_waitrequest;
  logic [6:0] scan_addr, address_pointer, shift_ofs;
  logic [7:0] scan_char;
  logic [7:0] wq[$];
  int n_mismatch, num_checks, cycles;
  // Command, expected display/cursor/blink, pointer and screen shift.
  clcd_row_type rows[25] = '{
    '{10'h001, 3'h0, 7'h00, 7'h00}, '{10'h00f, 3'h7, 7'h00, 7'h00},
    '{10'h006, 3'h7, 7'h00, 7'h00}, '{10'h141, 3'h7, 7'h01, 7'h00},
    '{10'h014, 3'h7, 7'h02, 7'h00}, '{10'h010, 3'h7, 7'h01, 7'h00},
    '{10'h018, 3'h7, 7'h01, 7'h01}, '{10'h01c, 3'h7, 7'h01, 7'h00},
    '{10'h01b, 3'h7, 7'h01, 7'h01}, '{10'h003, 3'h7, 7'h00, 7'h00},
    '{10'h007, 3'h7, 7'h00, 7'h00}, '{10'h142, 3'h7, 7'h01, 7'h01},
    '{10'h005, 3'h7, 7'h01, 7'h01}, '{10'h143, 3'h7, 7'h00, 7'h00},
    '{10'h300, 3'h7, 7'h67, 7'h00},
    '{10'h045, 3'h7, 7'h05, 7'h00}, '{10'h1aa, 3'h7, 7'h04, 7'h00},
    '{10'h0a7, 3'h7, 7'h27, 7'h00}, '{10'h006, 3'h7, 7'h27, 7'h00},
    '{10'h014, 3'h7, 7'h40, 7'h00}, '{10'h085, 3'h7, 7'h05, 7'h00},
    '{10'h004, 3'h7, 7'h05, 7'h00}, '{10'h00d, 3'h5, 7'h05, 7'h00},
    '{10'h160, 3'h5, 7'h04, 7'h00}, '{10'h008, 3'h0, 7'h04, 7'h00}};

  clcd_if u_clcd_if();
  clcd_device u_clcd_device (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .lnk(u_clcd_if.device), .scan_addr(scan_addr), .scan_char(scan_char),
    .disp_on(disp_on), .cursor_vis(cursor_vis), .blink_on(blink_on),
    .address_pointer(address_pointer), .shift_ofs(shift_ofs),
    .two_line(two_line), .busy_indicator(busy_indicator));
  clcd_host u_clcd_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .lnk(u_clcd_if.host), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  clcd_properties u_clcd_properties (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .rs(u_clcd_if.rs), .rw(u_clcd_if.rw), .en(u_clcd_if.en),
    .host_db(u_clcd_if.host_db), .host_db_oe(u_clcd_if.host_db_oe),
    .dev_db_oe(u_clcd_if.dev_db_oe));

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 sys_clk = ~sys_clk;

  // Records the bus at each write strobe fall, while capture is on.
  always @(posedge sys_clk) begin
    en_q <= u_clcd_if.en;
    if (cap && en_q && !u_clcd_if.en && !u_clcd_if.rw) begin
      wq.push_back(u_clcd_if.db_level);
    end
  end

  // A hang would otherwise stall the run; the ceiling is well above need.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus cycle; the request holds until waitrequest is seen low.
  task av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  // Waits for the host engine to finish, then lets the outputs settle.
  task idle;
    repeat (4000) begin
      av(REG_STATUS, 1'b0, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (q[0] !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (8) @(posedge sys_clk);
  endtask : idle

  task job(input logic [9:0] c);
    av(REG_CMD, 1'b1, {22'h0, c});
    idle();
  endtask : job

  // Shows one memory cell and waits a bounded time for a character.
  task look(input logic [6:0] a, input logic [7:0] e, input int n);
    scan_addr <= a;
    repeat (n) begin
      @(posedge sys_clk);
      if (scan_char === e) break;
    end
    chk(32'(scan_char), 32'(e));
  endtask : look

  task wrap_up;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence: reset, the table of commands, then awkward cases.
  initial begin
    sys_rst = 1'b1;
    {avs_read, avs_write, cap, en_q} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    scan_addr = 7'h00;
    {n_mismatch, num_checks, cycles} = '0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk(32'({two_line, disp_on, address_pointer}), 32'h100);
    av(REG_CTRL, 1'b0, 32'h0);
    chk(q, 32'h1);
    av(4'hc, 1'b1, 32'hff);
    av(4'hc, 1'b0, 32'h0);
    chk(q, 32'h0);
    av(REG_STATUS, 1'b0, 32'h0);
    chk(q & 32'h2, 32'h2);
    foreach (rows[i]) begin
      job(rows[i].c);
      chk(32'({disp_on, cursor_vis, blink_on}), 32'(rows[i].dcb));
      chk(32'(address_pointer), 32'(rows[i].ptr));
      chk(32'(shift_ofs), 32'(rows[i].sh));
    end
    look(7'h00, 8'h20, 4);
    job(10'h00c);
    look(7'h01, 8'h43, 4);
    job(10'h00f);
    job(10'h080);
    look(7'h00, 8'hff, 30000);
    look(7'h00, 8'h42, 30000);
    job(10'h004);
    job(10'h001);
    chk(32'({address_pointer, shift_ofs}), 32'h0);
    look(7'h05, 8'h20, 4);
    job(10'h141);
    chk(32'(address_pointer), 32'h1);
    // Wide byte, a width change, then a byte split into two nibbles.
    cap <= 1'b1;
    job(10'h144);
    job(10'h028);
    job(10'h1a5);
    cap <= 1'b0;
    chk({wq[0], wq[1], wq[2], wq[3]}, 32'h4428a050);
    look(7'h02, 8'ha5, 4);
    av(REG_STATUS, 1'b0, 32'h0);
    chk(q & 32'h2, 32'h0);
    // The last write's busy time must run out, or the next unpolled
    // write would be dropped by the device.
    repeat ((BUSY_OSC_TICKS + 1) * OSC_DIV_CYC) @(posedge sys_clk);
    chk(32'(busy_indicator), 32'h0);
    // Without polling, a status read straight after a write sees busy.
    av(REG_CTRL, 1'b1, 32'h0);
    av(REG_CMD, 1'b1, 32'h177);
    av(REG_CMD, 1'b1, 32'h200);
    idle();
    chk(q & 32'hff00, 32'h8400);
    chk(32'(busy_indicator), 32'h1);
    // Polling back on, so the line count change waits for ready.
    av(REG_CTRL, 1'b1, 32'h1);
    job(10'h020);
    chk(32'(two_line), 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    av(REG_STATUS, 1'b0, 32'h0);
    chk(q & 32'h3, 32'h2);
    chk(32'({two_line, address_pointer}), 32'h80);
    wrap_up();
  end
endmodule : char_lcd_command_decoder_bench

// File: clcd_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: Select picks instruction or data; direction high reads.
// R02: Wide mode moves a byte per transfer.
// R03: Narrow mode: two transfers, high nibble first.
// R04: Busy reads one on line seven; host polls.
// R05: Host waits half oscillator period after ready.
// R06: Clear fills spaces, pointer zero, increment set.
// R07: Home zeroes pointer and shift, memory kept.
// R08: Entry mode stores direction and scroll bits.
// R09: Glyph accesses step pointer like display accesses.
// R10: Scroll shifts screen on display writes only.
// R11: Display control holds on, cursor, blink bits.
// R12: Hiding cursor leaves entry direction unchanged.
// R13: Blink alternates all ones and stored character.
// R14: Shift moves cursor or screen, memory untouched.
// R15: Two-line cursor wraps from position forty onward.
// R16: Screen shift leaves pointer unchanged, all lines.
// R17: Shift codes: cursor left/right, screen left/right.
// R18: Width bit: one wide, zero narrow transfers.
// R19: Line bit: one two-line, zero one-line.
// R20: Act on strobe fall, drive reads while high.
module clcd_device import clcd_pkg::*; (
  input wire logic sys_clk, // System clock, 25 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  clcd_if.device lnk, // Parallel bus from the host.
  input wire logic [6:0] scan_addr, // Display memory address to show.
  output logic [7:0] scan_char, // Character code at scan_addr.
  output logic disp_on, // Display enabled.
  output logic cursor_vis, // Cursor shown.
  output logic blink_on, // Cursor blink enabled.
  output logic [6:0] address_pointer, // Current memory pointer.
  output logic [6:0] shift_ofs, // Whole screen shift amount.
  output logic two_line, // Two-line mode.
  output logic busy_indicator // Internal operation running.
);

  logic [7:0] db_s;
  logic en_s;
  logic rs_s;
  logic rw_s;
  logic en_d;
  logic bus_width_sel;
  logic nib;
  logic [3:0] hi_nib;
  logic [7:0] out_byte;
  logic inc_dir;
  logic whole_screen_scroll;
  logic sel_glyph;
  logic [6:0] osc_cnt;
  logic osc_tick;
  logic [3:0] busy_cnt;
  logic [7:0] blink_cnt;
  logic blink_phase;
  logic clr_active;
  logic [6:0] clr_idx;
  logic busy;
  logic rise;
  logic fall;
  logic byte_done;
  logic [7:0] full_byte;
  logic [7:0] rd_src;
  logic do_instr;
  logic do_wdata;
  logic do_rdata;
  logic [7:0] char_display_memory [0:CHAR_DISPLAY_MEMORY_DEPTH-1];
  logic [7:0] glyph_pattern_memory [0:GLYPH_DEPTH-1];

  // Pointer stepping shared by display and glyph accesses.
  function automatic logic [6:0] step_addr(input logic [6:0] a,
      input logic up, input logic glyph, input logic two);
    logic [5:0] g;
    g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
    if (glyph) begin
      return {1'b0, g}; // R09
    end else if (two) begin
      if (up) begin
        return (a == LINE1_LAST) ? LINE2_FIRST : // R15
               (a == LINE2_LAST) ? HOME_ADDR : a + 7'h01;
      end
      return (a == HOME_ADDR) ? LINE2_LAST :
             (a == LINE2_FIRST) ? LINE1_LAST : a - 7'h01;
    end else if (up) begin
      return (a == ONE_LINE_LAST) ? HOME_ADDR : a + 7'h01;
    end
    return (a == HOME_ADDR) ? ONE_LINE_LAST : a - 7'h01;
  endfunction : step_addr

  // Screen shift wraps within one line's length.
  function automatic logic [6:0] step_ofs(input logic [6:0] o,
      input logic left, input logic two);
    logic [6:0] last;
    last = two ? LINE1_LAST : ONE_LINE_LAST;
    if (left) begin
      return (o == last) ? HOME_ADDR : o + 7'h01;
    end
    return (o == HOME_ADDR) ? last : o - 7'h01;
  endfunction : step_ofs

  // Bus pins come from another party and are synchronised.
  clcd_sync #(.W(11)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d({lnk.en, lnk.rs, lnk.rw, lnk.db_level}),
    .q({en_s, rs_s, rw_s, db_s})
  );

  // Strobe edges and the completed byte.
  assign rise = en_s & ~en_d;
  assign fall = ~en_s & en_d; // R20
  assign byte_done = fall & (bus_width_sel | nib); // R02 R03
  assign full_byte = bus_width_sel ? db_s : {hi_nib, db_s[7:4]}; // R03
  assign busy = (busy_cnt != 4'h0) | clr_active;
  // Writes during an internal operation are dropped; reads always work.
  assign do_instr = byte_done & ~rs_s & ~rw_s & ~busy; // R01
  assign do_wdata = byte_done & rs_s & ~rw_s & ~busy; // R01
  assign do_rdata = byte_done & rs_s & rw_s; // R01
  assign rd_src = ~rs_s ? {busy, address_pointer} : // R04
                  sel_glyph ? glyph_pattern_memory[address_pointer[5:0]] :
                  char_display_memory[address_pointer];

  // Link side: nibble tracking and read data drive.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_d <= 1'b0;
      nib <= 1'b0;
      hi_nib <= 4'h0;
      out_byte <= 8'h00;
      lnk.dev_db <= 8'h00;
      lnk.dev_db_oe <= 1'b0;
    end else begin
      en_d <= en_s;
      lnk.dev_db_oe <= en_s & rw_s; // R20
      if (rise && rw_s) begin
        if (bus_width_sel) begin
          lnk.dev_db <= rd_src; // R02
        end else if (!nib) begin
          out_byte <= rd_src;
          lnk.dev_db <= {rd_src[7:4], 4'h0}; // R03
        end else begin
          lnk.dev_db <= {out_byte[3:0], 4'h0}; // R03
        end
      end
      if (byte_done) begin
        nib <= 1'b0;
      end else if (fall && !bus_width_sel) begin
        nib <= 1'b1;
        hi_nib <= db_s[7:4]; // R03
      end
    end
  end

  // Instruction decode and the pointer, mode and shift state.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      address_pointer <= HOME_ADDR;
      shift_ofs <= HOME_ADDR;
      bus_width_sel <= WIDE_RESET;
      two_line <= TWO_LINE_RESET;
      inc_dir <= 1'b1;
      whole_screen_scroll <= 1'b0;
      sel_glyph <= 1'b0;
      disp_on <= 1'b0;
      cursor_vis <= 1'b0;
      blink_on <= 1'b0;
    end else if (do_instr) begin
      if (full_byte[DISP_ADDR_BIT]) begin
        address_pointer <= full_byte[6:0];
        sel_glyph <= 1'b0;
      end else if (full_byte[GLYPH_ADDR_BIT]) begin
        address_pointer <= {1'b0, full_byte[5:0]};
        sel_glyph <= 1'b1;
      end else if (full_byte[FUNC_BIT]) begin
        bus_width_sel <= full_byte[4]; // R18
        two_line <= full_byte[3]; // R19
      end else if (full_byte[SHIFT_BIT]) begin
        if (full_byte[3]) begin
          // Pointer is left alone; one offset moves every line. R16
          shift_ofs <= step_ofs(shift_ofs, ~full_byte[2], two_line); // R17
        end else begin
          address_pointer <= step_addr(address_pointer, full_byte[2],
                                       sel_glyph, two_line); // R14 R17
        end
      end else if (full_byte[DISPCTL_BIT]) begin
        disp_on <= full_byte[2]; // R11
        cursor_vis <= full_byte[1]; // R12
        blink_on <= full_byte[0]; // R13
      end else if (full_byte[ENTRY_BIT]) begin
        inc_dir <= full_byte[1]; // R08
        whole_screen_scroll <= full_byte[0]; // R08
      end else if (full_byte[HOME_BIT]) begin
        address_pointer <= HOME_ADDR; // R07
        shift_ofs <= HOME_ADDR; // R07
      end else if (full_byte[CLEAR_BIT]) begin
        address_pointer <= HOME_ADDR; // R06
        shift_ofs <= HOME_ADDR; // R06
        inc_dir <= 1'b1; // R06
        sel_glyph <= 1'b0;
      end
    end else if (do_wdata || do_rdata) begin
      address_pointer <= step_addr(address_pointer, inc_dir, sel_glyph,
                                   two_line); // R08 R09
      if (do_wdata && whole_screen_scroll && !sel_glyph) begin
        shift_ofs <= step_ofs(shift_ofs, inc_dir, two_line); // R10
      end
    end
  end

  // Clear sweeps every display memory address, one per clock.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_active <= 1'b0;
      clr_idx <= HOME_ADDR;
    end else if (clr_active) begin
      clr_idx <= clr_idx + 7'h01;
      clr_active <= (clr_idx != CLR_LAST);
    end else if (do_instr && full_byte[7:1] == 7'h00 && full_byte[0]) begin
      clr_active <= 1'b1; // R06
      clr_idx <= HOME_ADDR;
    end
  end

  // Memory writes; no reset, as in a real character memory.
  always_ff @(posedge sys_clk) begin
    if (clr_active) begin
      char_display_memory[clr_idx] <= SPACE_CODE; // R06
    end else if (do_wdata && sel_glyph) begin
      glyph_pattern_memory[address_pointer[5:0]] <= full_byte;
    end else if (do_wdata) begin
      char_display_memory[address_pointer] <= full_byte;
    end
  end

  // Internal oscillator as an enable, busy timer and blink phase.
  assign osc_tick = (osc_cnt == 7'(OSC_DIV_CYC - 1));
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_cnt <= 7'h00;
      busy_cnt <= 4'h0;
      blink_cnt <= 8'h00;
      blink_phase <= 1'b0;
      busy_indicator <= 1'b0;
    end else begin
      osc_cnt <= osc_tick ? 7'h00 : osc_cnt + 7'h01;
      busy_indicator <= busy; // R04
      if (do_instr || do_wdata) begin
        busy_cnt <= 4'(BUSY_OSC_TICKS);
      end else if (osc_tick && busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end
      if (osc_tick) begin
        if (blink_cnt == 8'(BLINK_OSC_TICKS - 1)) begin
          blink_cnt <= 8'h00;
          blink_phase <= ~blink_phase;
        end else begin
          blink_cnt <= blink_cnt + 8'h01;
        end
      end
    end
  end

  // Scan output: blanked when off, blink overlays the cursor cell.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_char <= SPACE_CODE;
    end else if (!disp_on) begin
      scan_char <= SPACE_CODE; // R11
    end else if (blink_on && blink_phase && !sel_glyph &&
                 scan_addr == address_pointer) begin
      scan_char <= ALL_ONES; // R13
    end else begin
      scan_char <= char_display_memory[scan_addr]; // R13
    end
  end

endmodule : clcd_device

// File: clcd_host.sv
`timescale 1ns/1ps
module clcd_host import clcd_pkg::*; (
  input wire logic sys_clk, // System clock, 25 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  clcd_if.host lnk, // Parallel bus to the display.
  input wire logic [3:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest // Stall, high until accepted.
);

  typedef enum {H_IDLE, H_SETUP, H_HIGH, H_HOLD, H_GAP} clcd_hst_type;
  clcd_hst_type state;
  logic [7:0] db_s;
  logic [6:0] cnt;
  logic polling;
  logic nib;
  logic wide;
  logic poll_en;
  logic job_rs;
  logic job_rw;
  logic [7:0] job_byte;
  logic [7:0] rd_byte;
  logic [7:0] last_rd;
  logic req;
  logic can_take;
  logic cmd_go;
  logic cur_rs;
  logic cur_rw;

  clcd_sync #(.W(8)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(lnk.db_level),
    .q(db_s)
  );

  // A command write stalls until the previous job has finished.
  assign req = avs_read | avs_write;
  assign can_take = ~(avs_write & avs_address == REG_CMD) |
                    (state == H_IDLE);
  assign cmd_go = avs_write & ~avs_waitrequest & avs_address == REG_CMD;
  // While polling, the busy read replaces the job's own transfer.
  assign cur_rs = polling ? 1'b0 : job_rs;
  assign cur_rw = polling ? 1'b1 : job_rw;

  // Avalon slave: answer one cycle after the request, stall on busy.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      poll_en <= CTRL_POLL_RESET;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest & can_take);
      if (req && avs_waitrequest && can_take) begin
        case (avs_address)
          REG_STATUS: avs_readdata <= {16'h0000, last_rd, 6'h00, wide,
                                       state != H_IDLE};
          REG_CTRL: avs_readdata <= {31'h00000000, poll_en};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
        poll_en <= avs_writedata[0];
      end
    end
  end

  // Transfer engine: busy poll, half oscillator gap, then the byte.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= H_IDLE;
      cnt <= 7'h00;
      polling <= 1'b0;
      nib <= 1'b0;
      wide <= WIDE_RESET;
      job_rs <= 1'b0;
      job_rw <= 1'b0;
      job_byte <= 8'h00;
      rd_byte <= 8'h00;
      last_rd <= 8'h00;
      lnk.rs <= 1'b0;
      lnk.rw <= 1'b0;
      lnk.en <= 1'b0;
      lnk.host_db <= 8'h00;
      lnk.host_db_oe <= 1'b0;
    end else begin
      cnt <= cnt + 7'h01;
      case (state)
        H_IDLE: begin
          lnk.host_db_oe <= 1'b0;
          if (cmd_go) begin
            job_byte <= avs_writedata[7:0];
            job_rs <= avs_writedata[CMD_RS_BIT];
            job_rw <= avs_writedata[CMD_RD_BIT];
            // Any instruction or data write waits for ready first.
            polling <= poll_en & ~(~avs_writedata[CMD_RS_BIT] &
                                   avs_writedata[CMD_RD_BIT]); // R04
            nib <= 1'b0;
            cnt <= 7'h00;
            state <= H_SETUP;
          end
        end
        H_SETUP: begin
          lnk.rs <= cur_rs; // R01
          lnk.rw <= cur_rw; // R01
          lnk.host_db_oe <= ~cur_rw;
          lnk.host_db <= wide ? job_byte : // R02 R18
                         nib ? {job_byte[3:0], 4'h0} :
                         {job_byte[7:4], 4'h0}; // R03
          if (cnt == 7'(SETUP_CYC - 1)) begin
            lnk.en <= 1'b1;
            cnt <= 7'h00;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (cnt == 7'(HIGH_CYC - 1)) begin
            if (wide) begin
              rd_byte <= db_s;
            end else if (!nib) begin
              rd_byte[7:4] <= db_s[7:4]; // R03
            end else begin
              rd_byte[3:0] <= db_s[7:4];
            end
            lnk.en <= 1'b0; // R20
            cnt <= 7'h00;
            state <= H_HOLD;
          end
        end
        H_HOLD: begin
          if (cnt == 7'(HOLD_CYC - 1)) begin
            cnt <= 7'h00;
            if (!wide && !nib) begin
              nib <= 1'b1;
              state <= H_SETUP;
            end else if (polling) begin
              nib <= 1'b0;
              lnk.host_db_oe <= 1'b0;
              // Poll again while busy, else go to the gap.
              polling <= rd_byte[BUSY_BIT]; // R04
              state <= rd_byte[BUSY_BIT] ? H_SETUP : H_GAP;
            end else begin
              nib <= 1'b0;
              lnk.host_db_oe <= 1'b0;
              if (job_rw) begin
                last_rd <= rd_byte;
              end
              if (!job_rs && !job_rw && job_byte[7:5] == 3'h1) begin
                wide <= job_byte[4]; // R18
              end
              state <= H_IDLE;
            end
          end
        end
        H_GAP: begin
          if (cnt == 7'(HALF_OSC_CYC - 1)) begin
            cnt <= 7'h00;
            state <= H_SETUP; // R05
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule : clcd_host

// File: clcd_if.sv
`timescale 1ns/1ps
interface clcd_if;
  logic rs;
  logic rw;
  logic en;
  logic [7:0] host_db;
  logic host_db_oe;
  logic [7:0] dev_db;
  logic dev_db_oe;
  logic [7:0] db_level;

  // Resolved data bus; an undriven bus floats high as with pull-ups.
  assign db_level = host_db_oe ? host_db : (dev_db_oe ? dev_db : 8'hff);

  modport host (
    output rs, rw, en, host_db, host_db_oe,
    input db_level
  );
  modport device (
    output dev_db, dev_db_oe,
    input rs, rw, en, db_level
  );
endinterface : clcd_if

// File: clcd_pkg.sv
package clcd_pkg;

  // System clock and the controller's internal oscillator.
  localparam int CLK_KHZ = 25000;
  localparam int OSC_KHZ = 270;
  localparam int OSC_DIV_CYC = CLK_KHZ / OSC_KHZ;
  localparam int HALF_OSC_CYC = (OSC_DIV_CYC + 1) / 2;

  // Internal operation lengths, counted in oscillator ticks.
  localparam int BUSY_OSC_TICKS = 3;
  localparam int BLINK_OSC_TICKS = 128;

  // Host strobe timing in system clock cycles.
  // The strobe high time covers three sync stages on each end.
  localparam int SETUP_CYC = 2;
  localparam int HIGH_CYC = 10;
  localparam int HOLD_CYC = 4;

  // Instruction bit positions.
  localparam int CLEAR_BIT = 0;
  localparam int HOME_BIT = 1;
  localparam int ENTRY_BIT = 2;
  localparam int DISPCTL_BIT = 3;
  localparam int SHIFT_BIT = 4;
  localparam int FUNC_BIT = 5;
  localparam int GLYPH_ADDR_BIT = 6;
  localparam int DISP_ADDR_BIT = 7;
  localparam int BUSY_BIT = 7;

  // Memory sizes and display memory address map.
  localparam int CHAR_DISPLAY_MEMORY_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [6:0] HOME_ADDR = 7'h00;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
  localparam logic [6:0] CLR_LAST = 7'h7f;

  // Host register map (byte addresses) and fields.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam int CMD_RS_BIT = 8;
  localparam int CMD_RD_BIT = 9;
  localparam logic CTRL_POLL_RESET = 1'b1;
  localparam logic WIDE_RESET = 1'b1;
  localparam logic TWO_LINE_RESET = 1'b1;

endpackage : clcd_pkg

// File: clcd_properties.sv
`timescale 1ns/1ps
module clcd_properties import clcd_pkg::*; (
  input wire logic sys_clk, // System clock.
  input wire logic sys_rst, // Reset, active high.
  input wire logic rs, // Register select.
  input wire logic rw, // Direction, high reads.
  input wire logic en, // Transfer strobe.
  input wire logic [7:0] host_db, // Host data out.
  input wire logic host_db_oe, // Host drives the bus.
  input wire logic dev_db_oe // Device drives the bus.
);
  int unsigned hi_cnt;

  // Counts strobe high cycles, since a repetition cannot reach ten.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt <= 0;
    end else if (en) begin
      hi_cnt <= hi_cnt + 1;
    end else begin
      hi_cnt <= 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // A read strobe ending, and the start of any strobe.
  sequence s_read_end;
    $fell(en) ##0 rw;
  endsequence
  sequence s_strobe_up;
    $rose(en);
  endsequence

  property p_pulse_len;
    $fell(en) |-> hi_cnt == HIGH_CYC;
  endproperty
  property p_setup;
    s_strobe_up |-> $stable(rs) && $stable(rw);
  endproperty
  property p_ctl_held;
    $fell(en) |=> ($stable(rs) && $stable(rw))[*2];
  endproperty
  property p_wdata_held;
    en && !rw |-> host_db_oe && $stable(host_db);
  endproperty
  property p_no_clash;
    !(host_db_oe && dev_db_oe);
  endproperty
  property p_read_no_host;
    en && rw |-> !host_db_oe;
  endproperty
  property p_dev_on_read;
    $rose(dev_db_oe) |-> rw && en;
  endproperty
  property p_read_ready;
    s_read_end |-> $past(dev_db_oe);
  endproperty
  property p_read_release;
    s_read_end |-> ##[1:8] !dev_db_oe;
  endproperty

  a_pulse_len: assert property (p_pulse_len)
    else $error("strobe high time wrong");
  a_setup: assert property (p_setup)
    else $error("select or direction moved at strobe rise");
  a_ctl_held: assert property (p_ctl_held)
    else $error("select or direction moved after strobe fall");
  a_wdata_held: assert property (p_wdata_held)
    else $error("write data not held during strobe");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the bus");
  a_read_no_host: assert property (p_read_no_host)
    else $error("host drives bus during a read");
  a_dev_on_read: assert property (p_dev_on_read)
    else $error("device drove bus outside a read");
  a_read_ready: assert property (p_read_ready)
    else $error("read data missing at strobe fall");
  a_read_release: assert property (p_read_release)
    else $error("device kept the bus after a read");
endmodule : clcd_properties

// File: clcd_sync.sv
`timescale 1ns/1ps
module clcd_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous inputs.
  output logic [W-1:0] q // Filtered, synchronised outputs.
);

  // Three stages per bit; a change is taken once stages two and three
  // agree, so a single metastable sample never reaches the logic.
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    logic qr;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        qr <= 1'b0;
      end else begin
        s1 <= d[g];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          qr <= s3;
        end
      end
    end
    assign q[g] = qr;
  end

endmodule : clcd_sync
